// [rtl/remap_pkg.sv]
package remap_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PHYS_ADDR_4_OFF  = 8'h61;
  localparam logic [7:0] PHYS_ADDR_5_OFF  = 8'h62;
  localparam logic [7:0] PHYS_ADDR_6_OFF  = 8'h63;
  localparam logic [7:0] PHYS_ADDR_7_OFF  = 8'h64;
  localparam logic [7:0] ALIAS_ADDR_4_OFF = 8'h69;
  localparam logic [7:0] ALIAS_ADDR_7_OFF = 8'h6C;

  // ----------------------------------------------------------------
  // Field layout and sizes
  // ----------------------------------------------------------------
  localparam int         ADDR_MSB     = 7;
  localparam int         ADDR_LSB     = 1;
  localparam int         AUTO_ACK_BIT = 0;
  localparam int         NUM_PORTS    = 4;
  localparam int         NUM_ENTRIES  = 4;
  localparam logic [2:0] FIRST_ENTRY  = 3'h4;
  localparam logic [6:0] ADDR_RESET   = 7'h00;
  localparam logic [6:0] ALIAS_OFF    = 7'h00;
  localparam logic [7:0] DATA_RESET   = 8'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [6:0] addr;
  } xlat_req_t;

  typedef struct packed {
    logic       valid;
    logic       hit;
    logic [1:0] port;
    logic [2:0] entry;
    logic [6:0] addr;
    logic       auto_ack;
  } xlat_rsp_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// [rtl/remote_target_address_remap.sv]
`timescale 1ns/1ps

// Overview of operation
// - Entries 4-7 hold RW 7-bit address, reset zero.
// - Alias match substitutes stored address, then forwards.
// - Port select chooses which receive port's copy.
// - Physical entries 4-7 sit at 0x61-0x64.
// - Compare against alias; zero alias disables entry.
// - Auto-ack bit acknowledges every write to target.
module remote_target_address_remap (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Register access from the local control decoder
  input  wire remap_pkg::reg_req_t  reg_req,
  input  wire logic [1:0]           port_sel,
  output logic [7:0]                reg_rdata_r,
  output logic                      reg_hit_r,
  // Address translation toward the back control channel
  input  wire remap_pkg::xlat_req_t xlat_req,
  output remap_pkg::xlat_rsp_t      xlat_rsp_r
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Physical entry offsets are contiguous, so one subtraction gives the slot.
  function automatic logic [2:0] phys_slot(input logic [7:0] a);
    logic [7:0] d;
    d = a - remap_pkg::PHYS_ADDR_4_OFF;
    phys_slot = {(a >= remap_pkg::PHYS_ADDR_4_OFF) && (a <= remap_pkg::PHYS_ADDR_7_OFF), d[1:0]};
  endfunction

  function automatic logic [2:0] alias_slot(input logic [7:0] a);
    logic [7:0] d;
    d = a - remap_pkg::ALIAS_ADDR_4_OFF;
    alias_slot = {(a >= remap_pkg::ALIAS_ADDR_4_OFF) && (a <= remap_pkg::ALIAS_ADDR_7_OFF),
                  d[1:0]};
  endfunction

  // ----------------------------------------------------------------
  // Per-port tables
  // ----------------------------------------------------------------
  logic [6:0] phys_r    [remap_pkg::NUM_PORTS][remap_pkg::NUM_ENTRIES];
  logic [6:0] phys_nxt  [remap_pkg::NUM_PORTS][remap_pkg::NUM_ENTRIES];
  logic [7:0] alias_r   [remap_pkg::NUM_PORTS][remap_pkg::NUM_ENTRIES];
  logic [7:0] alias_nxt [remap_pkg::NUM_PORTS][remap_pkg::NUM_ENTRIES];
  logic [7:0] rdata_nxt;
  logic       hit_nxt;
  logic [2:0] wr_phys;
  logic [2:0] wr_alias;
  logic [2:0] rd_phys;
  logic [2:0] rd_alias;

  assign wr_phys  = phys_slot(reg_req.addr);
  assign wr_alias = alias_slot(reg_req.addr);
  assign rd_phys  = wr_phys;
  assign rd_alias = wr_alias;

  // Writes only reach the copy of the port chosen by port select.
  always_comb begin
    phys_nxt  = phys_r;
    alias_nxt = alias_r;
    if (reg_req.wr && wr_phys[2]) begin
      phys_nxt[port_sel][wr_phys[1:0]] =
        reg_req.wdata[remap_pkg::ADDR_MSB:remap_pkg::ADDR_LSB];
    end
    if (reg_req.wr && wr_alias[2]) begin
      alias_nxt[port_sel][wr_alias[1:0]] = reg_req.wdata;
    end
  end

  // Read data is registered; bit 0 of a physical entry is never stored.
  always_comb begin
    rdata_nxt = reg_rdata_r;
    hit_nxt   = 1'b0;
    if (reg_req.rd) begin
      rdata_nxt = remap_pkg::DATA_RESET;
      if (rd_phys[2]) begin
        rdata_nxt = {phys_r[port_sel][rd_phys[1:0]], 1'b0};
        hit_nxt   = 1'b1;
      end else if (rd_alias[2]) begin
        rdata_nxt = alias_r[port_sel][rd_alias[1:0]];
        hit_nxt   = 1'b1;
      end
    end
  end

  // Every copy of every port clears together; software must reprogram all
  // four tables after a reset, since no copy survives it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < remap_pkg::NUM_PORTS; p++) begin
        for (int e = 0; e < remap_pkg::NUM_ENTRIES; e++) begin
          phys_r[p][e]  <= remap_pkg::ADDR_RESET;
          alias_r[p][e] <= remap_pkg::DATA_RESET;
        end
      end
      reg_rdata_r <= remap_pkg::DATA_RESET;
      reg_hit_r   <= 1'b0;
    end else begin
      phys_r      <= phys_nxt;
      alias_r     <= alias_nxt;
      reg_rdata_r <= rdata_nxt;
      reg_hit_r   <= hit_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Alias match and substitution
  // ----------------------------------------------------------------
  // The scan runs from the highest slot down so the lowest port and entry
  // win when software has programmed the same alias twice.
  remap_pkg::xlat_rsp_t rsp_nxt;

  always_comb begin
    rsp_nxt       = '0;
    rsp_nxt.valid = xlat_req.valid;
    for (int p = remap_pkg::NUM_PORTS - 1; p >= 0; p--) begin
      for (int e = remap_pkg::NUM_ENTRIES - 1; e >= 0; e--) begin
        if (xlat_req.valid &&
            alias_r[p][e][remap_pkg::ADDR_MSB:remap_pkg::ADDR_LSB] != remap_pkg::ALIAS_OFF &&
            alias_r[p][e][remap_pkg::ADDR_MSB:remap_pkg::ADDR_LSB] == xlat_req.addr) begin
          rsp_nxt.hit      = 1'b1;
          rsp_nxt.port     = p[1:0];
          rsp_nxt.entry    = remap_pkg::FIRST_ENTRY + 3'(e);
          rsp_nxt.addr     = phys_r[p][e];
          rsp_nxt.auto_ack = xlat_req.write &&
                             alias_r[p][e][remap_pkg::AUTO_ACK_BIT];
        end
      end
    end
  end

  // The answer is registered so the channel side sees a clean one-cycle
  // pulse, at the cost of one cycle of lookup latency.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xlat_rsp_r <= '0;
    end else begin
      xlat_rsp_r <= rsp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Checks that compare a lookup answer with the tables look one cycle back, so
  // they step aside for a register write in that cycle: the answer was built
  // from the old contents while the tables already hold the new ones.
  a_phys_write_lands: assert property (@(posedge clk) disable iff (rst)
    (reg_req.wr && wr_phys[2]) |=>
      phys_r[$past(port_sel)][$past(wr_phys[1:0])] == $past(reg_req.wdata[7:1]))
    else $error("Physical entry write was not stored.");

  a_forward_substitutes: assert property (@(posedge clk) disable iff (rst)
    xlat_rsp_r.hit |-> xlat_rsp_r.valid && $past(xlat_req.valid) &&
      ($past(reg_req.wr) ||
       xlat_rsp_r.addr == phys_r[xlat_rsp_r.port][xlat_rsp_r.entry[1:0]]))
    else $error("Forwarded address is not the stored physical address.");

  a_port_isolated: assert property (@(posedge clk) disable iff (rst)
    (reg_req.wr && wr_phys[2]) |=>
      phys_r[$past(port_sel) + 2'h1][$past(wr_phys[1:0])] ==
        $past(phys_r[port_sel + 2'h1][wr_phys[1:0]]))
    else $error("Write reached a port that was not selected.");

  a_offset_decode: assert property (@(posedge clk) disable iff (rst)
    (reg_req.rd && reg_req.addr == remap_pkg::PHYS_ADDR_6_OFF) |=>
      reg_hit_r && reg_rdata_r[7:1] == phys_r[$past(port_sel)][2])
    else $error("Entry 6 not decoded at its offset.");

  a_zero_alias_off: assert property (@(posedge clk) disable iff (rst)
    xlat_rsp_r.hit |-> $past(xlat_req.addr) != remap_pkg::ALIAS_OFF)
    else $error("Zero alias produced a match.");

  a_auto_ack_write: assert property (@(posedge clk) disable iff (rst)
    xlat_rsp_r.auto_ack |-> xlat_rsp_r.hit && $past(xlat_req.write))
    else $error("Auto acknowledge given outside a matched write.");

  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    (reg_req.rd && rd_phys[2]) |=> reg_rdata_r[0] == 1'b0)
    else $error("Reserved bit read back as one.");

  a_miss_quiet: assert property (@(posedge clk) disable iff (rst)
    (xlat_req.valid ##1 !xlat_rsp_r.hit) |->
      xlat_rsp_r.valid && !xlat_rsp_r.auto_ack && xlat_rsp_r.addr == 7'h00)
    else $error("Missed lookup carried an address or an acknowledge.");

  a_valid_follows: assert property (@(posedge clk) disable iff (rst)
    xlat_rsp_r.valid == $past(xlat_req.valid))
    else $error("Lookup answer did not follow its request by one cycle.");

  a_match_is_alias: assert property (@(posedge clk) disable iff (rst)
    (xlat_rsp_r.hit && !$past(reg_req.wr)) |->
      alias_r[xlat_rsp_r.port][xlat_rsp_r.entry[1:0]][7:1] == $past(xlat_req.addr))
    else $error("Matched entry does not hold the requested alias.");

  a_alias_write_lands: assert property (@(posedge clk) disable iff (rst)
    (reg_req.wr && wr_alias[2]) |=>
      alias_r[$past(port_sel)][$past(wr_alias[1:0])] == $past(reg_req.wdata))
    else $error("Alias entry write was not stored.");

  a_auto_ack_given: assert property (@(posedge clk) disable iff (rst)
    (xlat_rsp_r.hit && $past(xlat_req.write) && !$past(reg_req.wr)) |->
      xlat_rsp_r.auto_ack == alias_r[xlat_rsp_r.port][xlat_rsp_r.entry[1:0]][0])
    else $error("Auto acknowledge does not follow the matched entry.");

  a_phys_readback: assert property (@(posedge clk) disable iff (rst)
    (reg_req.rd && rd_phys[2]) |=>
      reg_rdata_r[7:1] == $past(phys_r[port_sel][rd_phys[1:0]]))
    else $error("Physical entry read returned another value.");

  a_hit_needs_read: assert property (@(posedge clk) disable iff (rst)
    reg_hit_r |-> $past(reg_req.rd))
    else $error("Register hit given without a read.");

  a_unmapped_quiet: assert property (@(posedge clk) disable iff (rst)
    (reg_req.rd && !rd_phys[2] && !rd_alias[2]) |=> !reg_hit_r && reg_rdata_r == 8'h00)
    else $error("Unmapped read was answered.");

endmodule // remote_target_address_remap

// [testbench/local_host_model.sv]
`timescale 1ns/1ps

// Local host that addresses remote targets through the remap block.
module local_host_model (
  // Clock
  input  wire logic            clk,
  // Address phase toward the remap block
  output remap_pkg::xlat_req_t xlat_req
);
  initial xlat_req = '0;

  // One address phase lasts one cycle; driving off the falling edge avoids races.
  task automatic send(input logic [6:0] a, input logic w);
    @(negedge clk);
    xlat_req = '{valid: 1'b1, write: w, addr: a};
    @(negedge clk);
    xlat_req = '0;
  endtask
endmodule // local_host_model

// [testbench/remote_target_address_remap_test.sv]
`timescale 1ns/1ps

module remote_target_address_remap_test;
  logic                 clk, rst;
  remap_pkg::reg_req_t  reg_req;
  logic [1:0]           port_sel;
  logic [7:0]           reg_rdata_r;
  logic                 reg_hit_r;
  remap_pkg::xlat_req_t xlat_req;
  remap_pkg::xlat_rsp_t xlat_rsp_r;
  int                   n_mismatch, samples_checked;
  logic [31:0]          seed;
  logic [7:0]           phys_m [4][4];
  logic [7:0]           alias_m [4][4];

  remote_target_address_remap i_dut (.clk(clk), .rst(rst), .reg_req(reg_req),
    .port_sel(port_sel), .reg_rdata_r(reg_rdata_r), .reg_hit_r(reg_hit_r),
    .xlat_req(xlat_req), .xlat_rsp_r(xlat_rsp_r));
  local_host_model i_host (.clk(clk), .xlat_req(xlat_req));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Register cycles: one strobe cycle, answer seen after the next rising edge.
  task automatic wr(input logic [1:0] p, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    port_sel = p;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    reg_req = '0;
  endtask

  task automatic rd(input logic [1:0] p, input logic [7:0] a, input logic [7:0] e, input logic h);
    @(negedge clk);
    port_sel = p;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    reg_req = '0;
    chk({8'h00, reg_rdata_r}, {8'h00, e});
    chk({15'h0000, reg_hit_r}, {15'h0000, h});
  endtask

  // Reference search: the lowest port, then the lowest entry, wins; zero alias never matches.
  function automatic remap_pkg::xlat_rsp_t want(input logic [6:0] a, input logic w);
    remap_pkg::xlat_rsp_t r;
    r = '0;
    r.valid = 1'b1;
    for (int p = 3; p >= 0; p--)
      for (int e = 3; e >= 0; e--)
        if (alias_m[p][e][7:1] != 7'h00 && alias_m[p][e][7:1] == a) begin
          r = '{1'b1, 1'b1, 2'(p), 3'(4 + e), phys_m[p][e][7:1], w & alias_m[p][e][0]};
        end
    return r;
  endfunction

  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end

  initial begin
    logic [6:0] a;
    logic       w;
    rst = 1'b1;
    reg_req = '0;
    port_sel = 2'h0;
    seed = 32'hD143;
    n_mismatch = 0;
    samples_checked = 0;
    // Count rising edges: the clock's first step to zero could pass for a falling edge.
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    // Reset values, and the offsets on either side of the table.
    for (int p = 0; p < 4; p++) begin
      for (int e = 0; e < 4; e++) begin
        rd(2'(p), 8'h61 + 8'(e), 8'h00, 1'b1);
        rd(2'(p), 8'h69 + 8'(e), 8'h00, 1'b1);
      end
      rd(2'(p), 8'h60, 8'h00, 1'b0);
      rd(2'(p), 8'h65, 8'h00, 1'b0);
    end
    // Per-port tables with a narrow alias range so zero aliases and clashes occur.
    for (int p = 0; p < 4; p++)
      for (int e = 0; e < 4; e++) begin
        phys_m[p][e] = 8'(xorshift());
        alias_m[p][e] = {3'h0, 5'(xorshift())};
        wr(2'(p), 8'h61 + 8'(e), phys_m[p][e]);
        wr(2'(p), 8'h69 + 8'(e), alias_m[p][e]);
        rd(2'(p), 8'h61 + 8'(e), {phys_m[p][e][7:1], 1'b0}, 1'b1);
        rd(2'(p), 8'h69 + 8'(e), alias_m[p][e], 1'b1);
      end
    for (int p = 0; p < 4; p++)
      for (int e = 0; e < 4; e++) rd(2'(p), 8'h61 + 8'(e), {phys_m[p][e][7:1], 1'b0}, 1'b1);
    // Translation of random local addresses, reads and writes alike.
    for (int i = 0; i < 60; i++) begin
      a = 7'(xorshift() & 32'hF);
      w = 1'(xorshift());
      i_host.send(a, w);
      chk(16'(xlat_rsp_r), 16'(want(a, w)));
    end
    i_host.send(7'h00, 1'b1);
    chk(16'(xlat_rsp_r), 16'(want(7'h00, 1'b1)));
    // A second reset in mid-run must clear every physical copy that was programmed above; one lookup then misses.
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (int p = 0; p < 4; p++) begin
      for (int e = 0; e < 4; e++) begin
        phys_m[p][e] = 8'h00;
        alias_m[p][e] = 8'h00;
        rd(2'(p), 8'h61 + 8'(e), 8'h00, 1'b1);
      end
    end
    i_host.send(7'h05, 1'b1);
    chk(16'(xlat_rsp_r), 16'(want(7'h05, 1'b1)));
    conclude();
  end
endmodule // remote_target_address_remap_test
